// >>> include/conv_timing_pkg.sv
package conv_timing_pkg;

	localparam logic [6:0] ADDR_DIGITAL_TIMING_SETUP = 7'h04;
	localparam logic [6:0] ADDR_ALTERNATE_SETUP      = 7'h05;

	localparam logic [7:0] RESET_DIGITAL_TIMING_SETUP = 8'h03;
	localparam logic [7:0] RESET_ALTERNATE_SETUP      = 8'h00;

	// Register words are 8 bits; the serial frame is command byte then data
	localparam int unsigned REG_WIDTH      = 8;
	localparam logic [3:0]  LAST_CMD_BIT   = 4'h7;
	localparam logic [3:0]  LAST_DATA_BIT  = 4'hf;

	// Period counts for each response-time code
	localparam int unsigned COUNT_WIDTH   = 16;
	localparam logic [15:0] PERIODS_192   = 16'h00c0;
	localparam logic [15:0] PERIODS_384   = 16'h0180;
	localparam logic [15:0] PERIODS_768   = 16'h0300;
	localparam logic [15:0] PERIODS_1536  = 16'h0600;
	localparam logic [15:0] PERIODS_3072  = 16'h0c00;
	localparam logic [15:0] PERIODS_5072  = 16'h13d0;

	// Conversion time is the period count over three sensor periods
	localparam logic [15:0] PERIOD_WEIGHT = 16'h0003;

	typedef struct packed {
		logic [3:0] sensor_floor_frequency;
		logic       reserved;
		logic [2:0] periods_per_conversion;
	} timing_setup_t;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic sdi;
	} serial_pins_t;

	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_CMD  = 2'b01,
		SER_DATA = 2'b11
	} serial_state_t;

endpackage

// >>> src/conv_period_timer.sv
`timescale 1ns/1ps
module conv_period_timer #(
	parameter int unsigned WIDTH = 16
) (
	input  wire logic               i_sys_clk,
	input  wire logic               i_reset,
	input  wire logic               i_start,
	input  wire logic               i_sensor_tick,
	input  wire logic [WIDTH-1:0]   i_target,
	output logic                    o_busy,
	output logic                    o_done
);
	import conv_timing_pkg::*;

	logic [WIDTH-1:0] acc;
	logic [WIDTH-1:0] target;
	logic             busy;
	logic             done;
	logic [WIDTH-1:0] next_acc;
	logic [WIDTH-1:0] next_target;
	logic             next_busy;
	logic             next_done;
	logic [WIDTH:0]   acc_step;

	assign acc_step = {1'b0, acc} + {1'b0, PERIOD_WEIGHT[WIDTH-1:0]};

	// Each sensor period weighs three, so the run lasts target/3 periods
	always_comb begin
		next_acc    = acc;
		next_target = target;
		next_busy   = busy;
		next_done   = 1'b0;
		if (i_start && !busy) begin
			next_acc    = '0;
			next_target = i_target; // see R9
			next_busy   = 1'b1;
		end else if (busy && i_sensor_tick) begin
			if (acc_step >= {1'b0, target}) begin // see R7
				next_busy = 1'b0;
				next_done = 1'b1;
				next_acc  = '0;
			end else begin
				next_acc = acc_step[WIDTH-1:0];
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			acc    <= '0;
			target <= '0;
			busy   <= 1'b0;
			done   <= 1'b0;
		end else begin
			acc    <= next_acc;
			target <= next_target;
			busy   <= next_busy;
			done   <= next_done;
		end
	end

	assign o_busy = busy;
	assign o_done = done;

	property p_done_reaches_target;
		@(posedge i_sys_clk) disable iff (i_reset)
		o_done |-> ($past(acc_step) >= {1'b0, $past(target)})
			&& $past(busy) && $past(i_sensor_tick);
	endproperty
	a_done_reaches_target: assert property (p_done_reaches_target) // see R7
		else $error("conversion ended before its period count");

endmodule

// >>> src/inductive_conv_timing_config.sv
`timescale 1ns/1ps
// Function
// R1: Timing setup register at 0x04, resets to 0x03.
// R2: Bits 7:4 code lowest sensor frequency, 16 minus 8 MHz over it.
// R3: Bits 2:0 select response time, sensor periods per conversion.
// R4: Codes 010..110 give 192 doubling to 3072; 111 gives 5072.
// R5: Host must never write response-time codes 000 or 001.
// R6: Response time steers only resistance and standard inductance paths.
// R7: Each affected conversion lasts response time over three sensor periods.
// R8: Alternate setup register at 0x05, resets to 0x00.
// R9: Timing field changes take effect only at next conversion start.
module inductive_conv_timing_config (
	input  wire logic                           i_sys_clk,
	input  wire logic                           i_reset,
	input  wire conv_timing_pkg::serial_pins_t  i_serial,
	output logic                                o_sdo,
	output logic                                o_sdo_oe_n,
	input  wire logic                           i_sensor_clk,
	input  wire logic                           i_conv_enable,
	output conv_timing_pkg::timing_setup_t      o_active_setup,
	output logic [15:0]                         o_periods_per_conversion,
	output logic [7:0]                          o_alternate_setup,
	output logic                                o_conv_busy,
	output logic                                o_conv_done
);
	import conv_timing_pkg::*;

	serial_pins_t  pins_meta;
	serial_pins_t  pins;
	logic          sclk_prev;
	logic [2:0]    sensor_sync;

	serial_state_t state;
	serial_state_t next_state;
	logic [3:0]    bit_cnt;
	logic [3:0]    next_bit_cnt;
	logic [6:0]    shift_in;
	logic [6:0]    next_shift_in;
	logic [7:0]    shift_out;
	logic [7:0]    next_shift_out;
	logic          is_read;
	logic          next_is_read;
	logic [6:0]    addr;
	logic [6:0]    next_addr;
	logic          sdo;
	logic          next_sdo;
	timing_setup_t digital_timing_setup;
	timing_setup_t next_digital_timing_setup;
	logic [7:0]    alternate_setup;
	logic [7:0]    next_alternate_setup;
	timing_setup_t active_setup;
	timing_setup_t next_active_setup;
	logic [15:0]   active_periods;
	logic [15:0]   next_active_periods;

	logic          sclk_rise;
	logic          sclk_fall;
	logic          sensor_tick;
	logic [7:0]    in_byte;
	logic [7:0]    read_data;
	logic          commit_write;
	logic          conv_start;
	logic          timer_busy;

	function automatic logic [15:0] periods_of(input logic [2:0] code);
		case (code)
			3'b011:  periods_of = PERIODS_384;
			3'b100:  periods_of = PERIODS_768;
			3'b101:  periods_of = PERIODS_1536;
			3'b110:  periods_of = PERIODS_3072;
			3'b111:  periods_of = PERIODS_5072;
			// Reserved codes fall back to the shortest count
			default: periods_of = PERIODS_192;
		endcase
	endfunction

	// Pins come from the host's domain: two flops before any use
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			pins_meta   <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
			pins        <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
			sclk_prev   <= 1'b0;
			sensor_sync <= 3'b000;
		end else begin
			pins_meta   <= i_serial;
			pins        <= pins_meta;
			sclk_prev   <= pins.sclk;
			sensor_sync <= {sensor_sync[1:0], i_sensor_clk};
		end
	end

	assign sclk_rise   = pins.sclk && !sclk_prev;
	assign sclk_fall   = !pins.sclk && sclk_prev;
	assign sensor_tick = sensor_sync[1] && !sensor_sync[2];
	assign in_byte     = {shift_in, pins.sdi};

	always_comb begin
		case (in_byte[6:0])
			ADDR_DIGITAL_TIMING_SETUP: read_data = digital_timing_setup;
			ADDR_ALTERNATE_SETUP:      read_data = alternate_setup;
			default:                   read_data = 8'h00;
		endcase
	end

	assign commit_write = (state == SER_DATA) && sclk_rise && !is_read
		&& (bit_cnt == LAST_DATA_BIT);

	// Serial port: mode 0, command byte {read, addr[6:0]} then one data byte
	always_comb begin
		next_state                = state;
		next_bit_cnt              = bit_cnt;
		next_shift_in             = shift_in;
		next_shift_out            = shift_out;
		next_is_read              = is_read;
		next_addr                 = addr;
		next_sdo                  = sdo;
		next_digital_timing_setup = digital_timing_setup;
		next_alternate_setup      = alternate_setup;
		if (pins.cs_n) begin
			next_state   = SER_IDLE;
			next_bit_cnt = 4'h0;
			next_sdo     = 1'b0;
		end else begin
			case (state)
				SER_IDLE: begin
					if (bit_cnt == 4'h0) begin
						next_state = SER_CMD;
					end
				end
				SER_CMD: begin
					if (sclk_rise) begin
						next_shift_in = in_byte[6:0];
						next_bit_cnt  = bit_cnt + 4'h1;
						if (bit_cnt == LAST_CMD_BIT) begin
							next_state     = SER_DATA;
							next_is_read   = in_byte[7];
							next_addr      = in_byte[6:0];
							next_shift_out = read_data;
						end
					end
				end
				SER_DATA: begin
					if (sclk_fall && is_read) begin
						next_sdo       = shift_out[7];
						next_shift_out = {shift_out[6:0], 1'b0};
					end
					if (sclk_rise) begin
						next_shift_in = in_byte[6:0];
						next_bit_cnt  = bit_cnt + 4'h1;
						// Further bytes in the frame are ignored
						if (bit_cnt == LAST_DATA_BIT) begin
							next_state   = SER_IDLE;
							next_bit_cnt = bit_cnt;
						end
					end
					if (commit_write) begin
						if (addr == ADDR_DIGITAL_TIMING_SETUP) begin
							next_digital_timing_setup = in_byte; // see R2 R3
						end
						if (addr == ADDR_ALTERNATE_SETUP) begin
							next_alternate_setup = in_byte;
						end
					end
				end
				default: next_state = SER_IDLE;
			endcase
		end
	end

	// Timing fields are copied only when a conversion starts
	assign conv_start = i_conv_enable && !timer_busy;

	always_comb begin
		next_active_setup   = active_setup;
		next_active_periods = active_periods;
		if (conv_start) begin
			next_active_setup   = digital_timing_setup; // see R9
			next_active_periods =
				periods_of(digital_timing_setup.periods_per_conversion); // see R4
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state                <= SER_IDLE;
			bit_cnt              <= 4'h0;
			shift_in             <= 7'h00;
			shift_out            <= 8'h00;
			is_read              <= 1'b0;
			addr                 <= 7'h00;
			sdo                  <= 1'b0;
			digital_timing_setup <= RESET_DIGITAL_TIMING_SETUP; // see R1
			alternate_setup      <= RESET_ALTERNATE_SETUP; // see R8
			active_setup         <= RESET_DIGITAL_TIMING_SETUP;
			active_periods       <= PERIODS_384;
		end else begin
			state                <= next_state;
			bit_cnt              <= next_bit_cnt;
			shift_in             <= next_shift_in;
			shift_out            <= next_shift_out;
			is_read              <= next_is_read;
			addr                 <= next_addr;
			sdo                  <= next_sdo;
			digital_timing_setup <= next_digital_timing_setup;
			alternate_setup      <= next_alternate_setup;
			active_setup         <= next_active_setup;
			active_periods       <= next_active_periods;
		end
	end

	// Only the resistance / standard inductance timer sees this count;
	// the high-resolution path has no input from it (see R6)
	conv_period_timer #(
		.WIDTH (COUNT_WIDTH)
	) u_timer (
		.i_sys_clk     (i_sys_clk),
		.i_reset       (i_reset),
		.i_start       (conv_start),
		.i_sensor_tick (sensor_tick),
		.i_target      (periods_of(digital_timing_setup.periods_per_conversion)),
		.o_busy        (timer_busy),
		.o_done        (o_conv_done)
	);

	assign o_sdo                    = sdo;
	assign o_sdo_oe_n               = !(is_read && state == SER_DATA);
	assign o_active_setup           = active_setup;
	assign o_periods_per_conversion = active_periods;
	assign o_alternate_setup        = alternate_setup;
	assign o_conv_busy              = timer_busy;

	property p_timing_reset;
		@(posedge i_sys_clk) $past(i_reset) |-> digital_timing_setup == 8'h03;
	endproperty
	a_timing_reset: assert property (p_timing_reset) // see R1
		else $error("timing setup not 0x03 after reset");

	property p_alternate_reset;
		@(posedge i_sys_clk) $past(i_reset) |-> alternate_setup == 8'h00;
	endproperty
	a_alternate_reset: assert property (p_alternate_reset) // see R8
		else $error("alternate setup not 0x00 after reset");

	property p_write_timing;
		@(posedge i_sys_clk) disable iff (i_reset)
		(commit_write && addr == 7'h04)
			|=> digital_timing_setup == $past(in_byte);
	endproperty
	a_write_timing: assert property (p_write_timing) // see R2
		else $error("write to timing setup not stored");

	property p_write_alternate;
		@(posedge i_sys_clk) disable iff (i_reset)
		(commit_write && addr == 7'h05)
			|=> alternate_setup == $past(in_byte);
	endproperty
	a_write_alternate: assert property (p_write_alternate) // see R8
		else $error("write to alternate setup not stored");

	property p_hold_mid_conversion;
		@(posedge i_sys_clk) disable iff (i_reset)
		!conv_start |=> $stable(active_setup) && $stable(active_periods);
	endproperty
	a_hold_mid_conversion: assert property (p_hold_mid_conversion) // see R9
		else $error("active timing changed during a conversion");

	property p_take_at_start;
		@(posedge i_sys_clk) disable iff (i_reset)
		conv_start |=> active_setup == $past(digital_timing_setup);
	endproperty
	a_take_at_start: assert property (p_take_at_start) // see R9
		else $error("setup not taken at conversion start");

	property p_default_count;
		@(posedge i_sys_clk) disable iff (i_reset)
		(active_setup.periods_per_conversion == 3'b011)
			|-> active_periods == 16'd384;
	endproperty
	a_default_count: assert property (p_default_count) // see R4
		else $error("code 011 does not give 384 periods");

	property p_top_count;
		@(posedge i_sys_clk) disable iff (i_reset)
		(active_setup.periods_per_conversion == 3'b111)
			|-> active_periods == 16'd5072;
	endproperty
	a_top_count: assert property (p_top_count) // see R4
		else $error("code 111 does not give 5072 periods");

	property p_field_code;
		@(posedge i_sys_clk) disable iff (i_reset)
		conv_start |=> o_periods_per_conversion
			== periods_of($past(digital_timing_setup[2:0]));
	endproperty
	a_field_code: assert property (p_field_code) // see R3
		else $error("response field not taken from bits 2:0");

endmodule

// >>> test/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model
	import conv_timing_pkg::*;
(
	input  wire logic    i_sys_clk,
	input  wire logic    i_sdo,
	input  wire logic    i_sdo_oe_n,
	output serial_pins_t o_pins
);
	logic oe_seen;

	initial begin
		o_pins = '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b1};
		oe_seen = 1'b0;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask

	// Mode 0, MSB first; six cycles a phase leaves room for the sync stages
	task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
		rd = 8'h00;
		oe_seen = 1'b0;
		o_pins.cs_n = 1'b0;
		wait_cyc(6);
		for (int b = 15; b >= 0; b--) begin
			o_pins.sdi = frame[b];
			wait_cyc(6);
			o_pins.sclk = 1'b1;
			if (b < 8) begin
				rd[b] = i_sdo;
				oe_seen = oe_seen | i_sdo_oe_n;
			end
			wait_cyc(6);
			o_pins.sclk = 1'b0;
		end
		// Released data line must not look like held data
		o_pins.sdi = ~o_pins.sdi;
		wait_cyc(6);
		o_pins.cs_n = 1'b1;
		wait_cyc(6);
	endtask
endmodule

// >>> test/tb_inductive_conv_timing_config.sv
`timescale 1ns/1ps
module tb_inductive_conv_timing_config;
	import conv_timing_pkg::*;

	typedef struct packed {
		logic [7:0]  setup;
		logic [15:0] per;
		logic [15:0] tk;
	} row_t;

	logic          i_sys_clk     = 1'b0;
	logic          i_reset       = 1'b1;
	logic          i_sensor_clk  = 1'b0;
	logic          i_conv_enable = 1'b0;
	serial_pins_t  pins;
	logic          sdo;
	logic          sdo_oe_n;
	logic          busy;
	logic          done;
	timing_setup_t act;
	logic [15:0]   per;
	logic [7:0]    alt;
	logic [7:0]    rd;
	int            num_errors    = 0;
	int            total_checks  = 0;
	int            ticks         = 0;
	int            slack         = 0;
	row_t          rows [6] = '{
		'{8'h02, PERIODS_192, 16'h0040},
		'{8'h13, PERIODS_384, 16'h0080},
		'{8'h54, PERIODS_768, 16'h0100},
		'{8'ha5, PERIODS_1536, 16'h0200},
		'{8'he6, PERIODS_3072, 16'h0400},
		'{8'hf7, PERIODS_5072, 16'h069b}
	};

	inductive_conv_timing_config i_dut (
		.i_sys_clk                (i_sys_clk),
		.i_reset                  (i_reset),
		.i_serial                 (pins),
		.o_sdo                    (sdo),
		.o_sdo_oe_n               (sdo_oe_n),
		.i_sensor_clk             (i_sensor_clk),
		.i_conv_enable            (i_conv_enable),
		.o_active_setup           (act),
		.o_periods_per_conversion (per),
		.o_alternate_setup        (alt),
		.o_conv_busy              (busy),
		.o_conv_done              (done)
	);

	serial_host_model i_host (
		.i_sys_clk  (i_sys_clk),
		.i_sdo      (sdo),
		.i_sdo_oe_n (sdo_oe_n),
		.o_pins     (pins)
	);

	initial forever #4 i_sys_clk = ~i_sys_clk;
	initial forever #32 i_sensor_clk = ~i_sensor_clk;

	always @(posedge i_sensor_clk) begin
		if (busy === 1'b1)
			ticks++;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Bounded wait on busy (which=0) or done (which=1)
	task automatic wait_sig(input logic which, input logic v);
		int n;
		n = 0;
		while ((which ? done : busy) !== v) begin
			@(posedge i_sys_clk);
			#1;
			n++;
			if (n > 20000) begin
				num_errors++;
				print_verdict();
			end
		end
	endtask

	task automatic do_reset();
		i_reset = 1'b1;
		repeat (2) @(posedge i_sys_clk);
		#1;
		i_reset = 1'b0;
		repeat (3) @(posedge i_sys_clk);
		#1;
		chk(16'(act), 16'h0003);
		chk(per, PERIODS_384);
		chk(16'({alt, busy, done, sdo_oe_n}), 16'h0001);
		i_host.xfer({8'h84, 8'h00}, rd);
		chk(16'(rd), 16'(RESET_DIGITAL_TIMING_SETUP));
		chk(16'(i_host.oe_seen), 16'h0000);
	endtask

	initial begin
		do_reset();
		i_host.xfer({8'h85, 8'h00}, rd);
		chk(16'(rd), 16'h0000);
		i_host.xfer({8'h05, 8'ha5}, rd);
		chk(16'(alt), 16'h00a5);
		i_host.xfer({8'h85, 8'h00}, rd);
		chk(16'(rd), 16'h00a5);
		// Unmapped place reads as zero and ignores writes
		i_host.xfer({8'h06, 8'h5a}, rd);
		i_host.xfer({8'h86, 8'h00}, rd);
		chk(16'(rd), 16'h0000);
		for (int r = 0; r < 6; r++) begin
			// Only codes 010..111 are ever written, floor set per row
			i_host.xfer({8'h04, rows[r].setup}, rd);
			i_host.xfer({8'h84, 8'h00}, rd);
			chk(16'(rd), 16'(rows[r].setup));
			i_conv_enable = 1'b1;
			wait_sig(1'b0, 1'b1);
			ticks = 0;
			chk(16'(act), 16'(rows[r].setup));
			chk(per, rows[r].per);
			i_host.xfer({8'h04, 8'hf2}, rd);
			chk(16'(act), 16'(rows[r].setup));
			wait_sig(1'b1, 1'b1);
			// Sync stages blur the count by one period either way
			slack = ticks - int'(rows[r].tk);
			chk(16'((slack >= -1) && (slack <= 1)), 16'h0001);
			@(posedge i_sys_clk);
			#1;
			chk(16'({done, busy}), 16'h0001);
			chk(16'(act), 16'h00f2);
			chk(per, PERIODS_192);
			i_conv_enable = 1'b0;
			wait_sig(1'b0, 1'b0);
		end
		do_reset();
		chk(16'(alt), 16'h0000);
		print_verdict();
	end
endmodule
